// ===== logic/gtc_pkg.sv
// constants, codes and carrier types for the general timer control block
`default_nettype none
package gtc_pkg;
    // ************************************************************
    // bus and register map (byte offsets)
    // ************************************************************
    localparam int GTC_AW = 8; // apb address width
    localparam logic [7:0] GTC_OFS_RELOAD = 8'h00; // timer_reload_value
    localparam logic [7:0] GTC_OFS_COUNT = 8'h04; // timer_current_count, ro
    localparam logic [7:0] GTC_OFS_CTRL = 8'h08; // timer_mode_control
    localparam logic [7:0] GTC_OFS_ICLR = 8'h0C; // timer_irq_clear, wo
    localparam logic [7:0] GTC_OFS_SNAP = 8'h10; // timer_event_snapshot, ro
    localparam logic [7:0] GTC_OFS_STAT = 8'h14; // sticky status, w1c
    localparam logic [7:0] GTC_OFS_MASK = 8'h18; // interrupt mask
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] GTC_WORD_RST = 32'h0000_0000;
    localparam logic [17:0] GTC_CTRL_RST = 18'h0_0000;
    localparam logic [1:0] GTC_ST_RST = 2'h0;
    // ************************************************************
    // status bit positions
    // ************************************************************
    localparam int GTC_ST_TMO = 0; // counter overflow
    localparam int GTC_ST_CAP = 1; // snapshot taken
    localparam int GTC_STW = 2; // status width
    // ************************************************************
    // field codes
    // ************************************************************
    localparam logic [2:0] GTC_CLK_LFO = 3'h0; // low-frequency oscillator
    localparam logic [2:0] GTC_CLK_CORE = 3'h1; // core clock
    localparam logic [2:0] GTC_CLK_PLL_A = 3'h2; // undivided_pll_clock
    localparam logic [2:0] GTC_CLK_PLL_B = 3'h3; // undivided_pll_clock
    localparam logic [1:0] GTC_FMT_BIN = 2'h0; // plain binary
    localparam logic [1:0] GTC_FMT_HMS23 = 2'h2; // h:m:s:c, 23 hours
    localparam logic [1:0] GTC_FMT_HMS255 = 2'h3; // h:m:s:c, 255 hours
    localparam logic [3:0] GTC_PRE_D16 = 4'h4; // divide by 16
    localparam logic [3:0] GTC_PRE_D256 = 4'h8; // divide by 256
    localparam logic [3:0] GTC_PRE_D32K = 4'hF; // divide by 32768
    // prescaler terminal counts (divide minus one)
    localparam logic [14:0] GTC_TC_D1 = 15'h0000;
    localparam logic [14:0] GTC_TC_D16 = 15'h000F;
    localparam logic [14:0] GTC_TC_D256 = 15'h00FF;
    localparam logic [14:0] GTC_TC_D32K = 15'h7FFF;
    // clock-format field limits
    localparam logic [7:0] GTC_HUND_MAX = 8'h63;
    localparam logic [7:0] GTC_MINSEC_MAX = 8'h3B;
    localparam logic [7:0] GTC_HR23_MAX = 8'h17;
    localparam logic [7:0] GTC_HR255_MAX = 8'hFF;
    localparam logic [31:0] GTC_ALL_ONES = 32'hFFFF_FFFF;
    // ************************************************************
    // control register layout, bits 17:0
    // ************************************************************
    typedef struct packed {
        logic cap_en; // 17 arm capture
        logic [4:0] evt_sel; // 16:12 capture source
        logic [2:0] clk_sel; // 11:9 prescaler input
        logic up; // 8 count direction
        logic en; // 7 run
        logic periodic; // 6 mode
        logic [1:0] fmt; // 5:4 format
        logic [3:0] pre; // 3:0 prescaler
    } gtc_ctrl_t;
endpackage : gtc_pkg
`default_nettype wire

// ===== logic/gtc_timer.sv
// general timer control: apb registers, prescaler, counter, capture, irq
// Contract
// R1: capture armed only while bit 17 set
// R2: bits 16:12 pick capture source 0..31
// R3: bit 8 one counts up, zero down
// R4: counter runs only while bit 7 set
// R5: bit 6 one periodic, zero free-running
// R6: bits 5:4 binary or clock formats
// R7: bits 3:0 divide by 1,16,256,32768
// R8: software writes zero to bits 31:18
// R9: bits 11:9 pick oscillator, core, pll
// R10: reload on overflow and on clear write
// R11: first source assertion copies count
// R12: any clear write drops pending interrupt; code drops only the overflow flag (bit 0), a pending capture flag stays
// R13: software avoids undocumented codes
`default_nettype none
module gtc_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gtc_pkg::GTC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lfo_tick,
    input wire logic pll_tick,
    input wire logic [31:0] irq_src,
    output logic irq
);
    import gtc_pkg::*;

    // ************************************************************
    // helper functions
    // ************************************************************
    // terminal count for a prescaler code
    function automatic logic [14:0] pre_tc(input logic [3:0] code);
        unique case (code)
            GTC_PRE_D16: pre_tc = GTC_TC_D16;
            GTC_PRE_D256: pre_tc = GTC_TC_D256;
            GTC_PRE_D32K: pre_tc = GTC_TC_D32K;
            // undocumented codes fall back to divide by one
            default: pre_tc = GTC_TC_D1;
        endcase
    endfunction : pre_tc

    // step one clock-format field, carry in and out in bit 8
    function automatic logic [8:0] fld_step(
        input logic [7:0] f,
        input logic [7:0] fmax,
        input logic up,
        input logic ci
    );
        // no carry in holds the field; counting up, a field at or above its limit rolls to zero
        fld_step = !ci ? {1'b0, f}
            : up ? ((f >= fmax) ? {1'b1, 8'h00} : {1'b0, f + 8'h01})
            : ((f == 8'h00) ? {1'b1, fmax} : {1'b0, f - 8'h01});
    endfunction : fld_step

    // ************************************************************
    // registers and wires
    // ************************************************************
    logic [31:0] reload_r; // timer_reload_value
    logic [31:0] count_r; // timer_current_count
    logic [31:0] snap_r; // timer_event_snapshot
    logic [17:0] ctrl_r; // timer_mode_control, implemented bits
    logic [GTC_STW-1:0] st_r; // sticky status
    logic [GTC_STW-1:0] mask_r; // interrupt mask
    logic [14:0] pre_cnt_r; // prescaler count
    logic sel_prev_r; // selected source, last cycle
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;
    gtc_ctrl_t ctl; // control viewed by field
    logic setup; // apb setup cycle
    logic wr_ok; // write takes effect now
    logic iclr_wr; // timer_refresh_strobe: clear register written
    logic src_tick; // selected source pulse
    logic tick; // prescaled count enable
    logic [31:0] step_val; // count after one step
    logic wrap; // step crosses the end of range
    logic sel_lvl; // selected capture source level
    logic cap_hit; // capture fires this cycle
    logic tmo_set; // overflow event this cycle
    logic [GTC_STW-1:0] st_clr; // status bits cleared this cycle
    logic [31:0] rd_mux;
    logic mapped;

    assign ctl = gtc_ctrl_t'(ctrl_r);

    // ************************************************************
    // apb slave
    // ************************************************************
    assign setup = psel && !penable;
    // one wait-free access: pready raised for the access cycle
    assign wr_ok = psel && penable && pready_r && pwrite && !pslverr_r;
    // R10: clear write strobe
    assign iclr_wr = wr_ok && (paddr == GTC_OFS_ICLR);

    // read decode, captured in the setup cycle
    always_comb
    begin
        rd_mux = GTC_WORD_RST;
        mapped = 1'b1;
        unique case (paddr)
            GTC_OFS_RELOAD: rd_mux = reload_r;
            GTC_OFS_COUNT: rd_mux = count_r;
            // reserved bits 31:18 read as zero
            GTC_OFS_CTRL: rd_mux = {14'h0000, ctrl_r};
            GTC_OFS_ICLR: rd_mux = GTC_WORD_RST;
            GTC_OFS_SNAP: rd_mux = snap_r;
            GTC_OFS_STAT: rd_mux = {30'h0000_0000, st_r};
            GTC_OFS_MASK: rd_mux = {30'h0000_0000, mask_r};
            // unmapped: zero data and an error answer
            default: mapped = 1'b0;
        endcase
    end

    // bus answer flops
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= GTC_WORD_RST;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
            // data sampled at setup so it stands through the access
            if (setup)
            begin
                prdata_r <= pwrite ? GTC_WORD_RST : rd_mux;
            end
        end
    end

    // software-written registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reload_r <= GTC_WORD_RST;
            ctrl_r <= GTC_CTRL_RST;
            mask_r <= GTC_ST_RST;
        end
        else if (wr_ok)
        begin
            if (paddr == GTC_OFS_RELOAD)
            begin
                reload_r <= pwdata;
            end
            // R8: upper bits are not stored, zero expected
            if (paddr == GTC_OFS_CTRL)
            begin
                ctrl_r <= pwdata[17:0];
            end
            if (paddr == GTC_OFS_MASK)
            begin
                mask_r <= pwdata[GTC_STW-1:0];
            end
        end
    end

    // ************************************************************
    // source select and prescaler
    // ************************************************************
    // R9: prescaler input choice
    always_comb
    begin
        unique case (ctl.clk_sel)
            GTC_CLK_LFO: src_tick = lfo_tick;
            GTC_CLK_CORE: src_tick = 1'b1;
            GTC_CLK_PLL_A, GTC_CLK_PLL_B: src_tick = pll_tick;
            // undocumented selections stall the timer
            default: src_tick = 1'b0;
        endcase
    end

    // R7: divide the source by the prescaler setting
    assign tick = ctl.en && src_tick && (pre_cnt_r >= pre_tc(ctl.pre));

    // prescaler counter; held at zero while disabled or refreshed
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_cnt_r <= 15'h0000;
        end
        else if (!ctl.en || iclr_wr)
        begin
            pre_cnt_r <= 15'h0000;
        end
        else if (src_tick)
        begin
            pre_cnt_r <= tick ? 15'h0000 : pre_cnt_r + 15'h0001;
        end
    end

    // ************************************************************
    // count step in the selected format
    // ************************************************************
    // R6: binary or hours:minutes:seconds:hundredths
    always_comb
    begin
        logic [8:0] hu;
        logic [8:0] se;
        logic [8:0] mi;
        logic [8:0] hr;
        hu = 9'h000;
        se = 9'h000;
        mi = 9'h000;
        hr = 9'h000;
        if (ctl.fmt == GTC_FMT_HMS23 || ctl.fmt == GTC_FMT_HMS255)
        begin
            hu = fld_step(count_r[7:0], GTC_HUND_MAX, ctl.up, 1'b1);
            se = fld_step(count_r[15:8], GTC_MINSEC_MAX, ctl.up, hu[8]);
            mi = fld_step(count_r[23:16], GTC_MINSEC_MAX, ctl.up, se[8]);
            hr = fld_step(count_r[31:24], ctl.fmt[0] ? GTC_HR255_MAX : GTC_HR23_MAX,
                ctl.up, mi[8]);
            step_val = {hr[7:0], mi[7:0], se[7:0], hu[7:0]};
            wrap = hr[8];
        end
        // R3: direction bit, down by default
        else if (ctl.up)
        begin
            // the carry out of the top bit is the wrap
            {wrap, step_val} = {1'b0, count_r} + 33'h0_0000_0001;
        end
        else
        begin
            // the reserved format code counts as binary
            step_val = count_r - 32'h0000_0001;
            wrap = (count_r == GTC_WORD_RST);
        end
    end

    // ************************************************************
    // counter
    // ************************************************************
    assign tmo_set = tick && wrap && !iclr_wr;

    // R4: counts only while enabled
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_r <= GTC_WORD_RST;
        end
        // R10: a clear write reloads at once
        else if (iclr_wr)
        begin
            count_r <= reload_r;
        end
        else if (tick)
        begin
            // R5: periodic reloads, free-running rolls over
            count_r <= (wrap && ctl.periodic) ? reload_r : step_val;
        end
    end

    // ************************************************************
    // event capture
    // ************************************************************
    // R2: pick one of 32 sources
    assign sel_lvl = irq_src[ctl.evt_sel];
    // R1: armed only with the capture bit set
    assign cap_hit = ctl.cap_en && sel_lvl && !sel_prev_r;

    // R11: copy the count on a rising source, counter keeps running
    // edge memory: a source already high when armed does not fire
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_prev_r <= 1'b0;
            snap_r <= GTC_WORD_RST;
        end
        else
        begin
            sel_prev_r <= sel_lvl;
            if (cap_hit)
            begin
                snap_r <= count_r;
            end
        end
    end

    // ************************************************************
    // interrupt status, mask and output
    // ************************************************************
    // R12: w1c write, and any clear write drops the overflow flag (bit 0)
    assign st_clr = ((wr_ok && paddr == GTC_OFS_STAT) ? pwdata[GTC_STW-1:0] : GTC_ST_RST)
        | GTC_STW'(iclr_wr);

    // set wins over a w1c clear in the same cycle, a clear write blocks the overflow set; irq level one cycle behind
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= GTC_ST_RST;
            irq_r <= 1'b0;
        end
        else
        begin
            st_r <= (st_r & ~st_clr) | {cap_hit, tmo_set};
            irq_r <= |(st_r & mask_r);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_cap_disarmed: assert property (!ctl.cap_en |=> $stable(snap_r)) // R1
        else $error("snapshot changed while capture disarmed");
    a_cap_copy: assert property ( // R11
        (ctl.cap_en && irq_src[ctl.evt_sel] && !sel_prev_r) |=> snap_r == $past(count_r))
        else $error("snapshot missed the count");
    a_cap_level: assert property ( // R11
        (ctl.cap_en && irq_src[ctl.evt_sel] && sel_prev_r) |=> $stable(snap_r))
        else $error("held source captured again");
    a_run_hold: assert property ((!ctl.en && !iclr_wr) |=> $stable(count_r)) // R4
        else $error("counter moved while disabled");
    a_bin_up: assert property ( // R3
        (tick && ctl.up && ctl.fmt == GTC_FMT_BIN && count_r != GTC_ALL_ONES && !iclr_wr)
        |=> count_r == $past(count_r) + 32'h0000_0001)
        else $error("up count step wrong");
    a_bin_down: assert property ( // R3
        (tick && !ctl.up && ctl.fmt == GTC_FMT_BIN && count_r != GTC_WORD_RST && !iclr_wr)
        |=> count_r == $past(count_r) - 32'h0000_0001)
        else $error("down count step wrong");
    a_clr_reload: assert property (iclr_wr |=> count_r == $past(reload_r)) // R10
        else $error("clear write did not reload");
    a_periodic: assert property ( // R5
        (tick && wrap && ctl.periodic && !iclr_wr) |=> count_r == $past(reload_r))
        else $error("periodic mode did not reload");
    a_free_roll: assert property ( // R5
        (tick && !ctl.up && ctl.fmt == GTC_FMT_BIN && !ctl.periodic
        && count_r == GTC_WORD_RST && !iclr_wr) |=> count_r == GTC_ALL_ONES)
        else $error("free-running did not roll over");
    a_hms_hund: assert property ( // R6
        (tick && ctl.up && ctl.fmt[1] && !ctl.periodic && count_r[7:0] == GTC_HUND_MAX && !iclr_wr)
        |=> count_r[7:0] == 8'h00)
        else $error("hundredths did not roll at 99");
    a_pre_div16: assert property ( // R7
        (ctl.en && ctl.pre == GTC_PRE_D16 && ctl.clk_sel == GTC_CLK_CORE && tick)
        |=> !tick [*8])
        else $error("divide by 16 ticked early");
    a_src_lfo: assert property ( // R9
        (ctl.clk_sel == GTC_CLK_LFO && !lfo_tick) |-> !tick)
        else $error("tick without oscillator pulse");
    a_clr_irq: assert property (iclr_wr |=> !st_r[GTC_ST_TMO]) // R12
        else $error("clear write left overflow pending");
    a_irq_out: assert property ((st_r[GTC_ST_TMO] && mask_r[GTC_ST_TMO]) |=> irq) // R12
        else $error("masked-in status did not raise irq");
endmodule : gtc_timer
`default_nettype wire

// ===== dv/test_general_timer_control.sv
// self-checking bench for the general timer control block
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        checked++; \
        if ((got) !== (ex)) \
        begin \
            num_errors++; \
            $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
        end \
    end
module test_general_timer_control import gtc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic rst_b;
    logic psel;
    logic penable;
    logic pwrite;
    logic [GTC_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lfo_tick;
    logic pll_tick;
    logic [31:0] irq_src;
    logic irq;
    logic [31:0] rdat; // data taken at the last access
    logic rerr; // error taken at the last access
    logic [3:0] tcnt; // free divider for the source pulses
    int num_errors;
    int checked;
    gtc_timer u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lfo_tick(lfo_tick),
        .pll_tick(pll_tick), .irq_src(irq_src), .irq(irq));
    // ****************************************
    // clock, source pulses, watchdog
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // oscillator pulse one edge in four, pll pulse one in two
    always @(posedge clk)
    begin
        tcnt <= tcnt + 4'h1;
        lfo_tick <= (tcnt[1:0] == 2'h0);
        pll_tick <= tcnt[0];
    end
    // the prescaler sweep dominates, about 34k cycles
    initial
    begin
        #(80000 * 10);
        num_errors++;
        $display("[FAIL] watchdog expected done seen hang");
        end_sim();
    end
    // ****************************************
    // tasks and expectation functions
    // ****************************************
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // wait however long the answer takes; only the watchdog ends a hang
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1);
        // the slave answers in the first access cycle, no wait state
        `CHK("access cycles", 1, n)
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one-hot level on a capture source for two cycles
    task automatic pulse(input logic [4:0] s);
        @(posedge clk);
        irq_src <= 32'h1 << s;
        repeat (2) @(posedge clk);
        irq_src <= 32'h0;
        @(posedge clk);
    endtask : pulse
    function automatic gtc_ctrl_t mk(input logic [2:0] cs, input logic u,
        input logic per, input logic [1:0] f, input logic [3:0] p);
        return '{clk_sel: cs, up: u, en: 1'b1, periodic: per, fmt: f, pre: p,
            default: '0};
    endfunction : mk
    // count after n ticks; only upward counting in clock format
    function automatic logic [31:0] adv(input logic [31:0] v, input gtc_ctrl_t c,
        input logic [31:0] ld, input int n);
        logic [7:0] hm;
        logic w;
        hm = c.fmt[0] ? 8'hFF : 8'h17;
        for (int i = 0; i < n; i++)
        begin
            w = c.fmt[1] ? (v == {hm, 24'h3B3B63}) : (v == (c.up ? 32'hFFFFFFFF : 32'h0));
            if (!c.fmt[1])
                v = c.up ? v + 32'h1 : v - 32'h1;
            else if (v[7:0] != 8'h63)
                v = v + 32'h1;
            else if (v[15:8] != 8'h3B)
                v = {v[31:16], v[15:8] + 8'h1, 8'h00};
            else if (v[23:16] != 8'h3B)
                v = {v[31:24], v[23:16] + 8'h1, 16'h0};
            else
                v = w ? 32'h0 : {v[31:24] + 8'h1, 24'h0};
            if (w && c.periodic)
                v = ld;
        end
        return v;
    endfunction : adv
    // load, refresh, run, then compare two reads spaced gap+3 edges
    task automatic run(input gtc_ctrl_t c, input logic [31:0] ld, input int gap,
        input int n);
        gtc_ctrl_t off;
        logic [31:0] r1;
        off = c;
        off.en = 1'b0;
        apb(1'b1, GTC_OFS_CTRL, {14'h0, off});
        apb(1'b1, GTC_OFS_RELOAD, ld);
        apb(1'b1, GTC_OFS_ICLR, $urandom);
        apb(1'b0, GTC_OFS_COUNT, 32'h0);
        `CHK("refresh", ld, rdat)
        apb(1'b1, GTC_OFS_CTRL, {14'h0, c});
        apb(1'b0, GTC_OFS_COUNT, 32'h0);
        r1 = rdat;
        repeat (gap) @(posedge clk);
        apb(1'b0, GTC_OFS_COUNT, 32'h0);
        `CHK("count", adv(r1, c, ld, n), rdat)
        $display("test run ctrl %h done", c);
    endtask : run
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        gtc_ctrl_t c;
        logic [31:0] ld;
        logic [4:0] sel;
        int gap;
        static int tk [4] = '{6, 24, 12, 12};
        static int dv [4] = '{1, 16, 256, 32768};
        static int ml [4] = '{4, 2, 2, 1};
        static logic [3:0] pr [4] = '{4'h0, 4'h4, 4'h8, 4'hF};
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {tcnt, lfo_tick, pll_tick, irq_src} = '0;
        num_errors = 0;
        checked = 0;
        void'($urandom(32'h08DB99E1));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 7; a++)
        begin
            apb(1'b0, 8'(4 * a), 32'h0);
            `CHK("reset value", 32'h0, rdat)
        end
        apb(1'b0, 8'h1C, 32'h0);
        `CHK("unmapped error", 1'b1, rerr)
        c = gtc_ctrl_t'($urandom);
        c.en = 1'b0;
        // only documented prescaler and format codes
        c.pre = pr[$urandom_range(3)];
        c.fmt = (c.fmt == 2'h1) ? GTC_FMT_BIN : c.fmt;
        apb(1'b1, GTC_OFS_CTRL, {14'h0, c});
        apb(1'b0, GTC_OFS_CTRL, 32'h0);
        `CHK("control readback", {14'h0, c}, rdat)
        $display("test registers done");
        for (int u = 0; u < 2; u++)
        begin
            gap = $urandom_range(12);
            run(mk(GTC_CLK_CORE, u[0], 1'b0, GTC_FMT_BIN, 4'h0), $urandom, gap, gap + 3);
        end
        c = mk(GTC_CLK_CORE, 1'b1, 1'b0, GTC_FMT_BIN, 4'h0);
        c.en = 1'b0;
        run(c, $urandom, 5, 0);
        for (int s = 0; s < 4; s++)
            run(mk(3'(s), 1'b1, 1'b0, GTC_FMT_BIN, 4'h0), $urandom, 21, tk[s]);
        for (int p = 0; p < 4; p++)
            run(mk(GTC_CLK_CORE, 1'b1, 1'b0, GTC_FMT_BIN, pr[p]), $urandom,
                dv[p] * ml[p] - 3, ml[p]);
        run(mk(GTC_CLK_CORE, 1'b0, 1'b0, GTC_FMT_BIN, 4'h0), 32'h3, 0, 3);
        run(mk(GTC_CLK_CORE, 1'b0, 1'b1, GTC_FMT_BIN, 4'h0), 32'h3, 0, 3);
        run(mk(GTC_CLK_CORE, 1'b1, 1'b0, GTC_FMT_HMS23, 4'h0), 32'h173B3B61, 0, 3);
        run(mk(GTC_CLK_CORE, 1'b1, 1'b0, GTC_FMT_HMS23, 4'h0), 32'h053A3B62, 0, 3);
        // the last run wraps, so the overflow flag stands for the interrupt test
        run(mk(GTC_CLK_CORE, 1'b1, 1'b0, GTC_FMT_HMS255, 4'h0), 32'hFF3B3B61, 0, 3);
        apb(1'b1, GTC_OFS_CTRL, 32'h0);
        apb(1'b1, GTC_OFS_MASK, 32'h0);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, GTC_OFS_MASK, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq raised", 1'b1, irq)
        apb(1'b1, GTC_OFS_ICLR, $urandom);
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        $display("test interrupt done");
        sel = 5'($urandom);
        ld = $urandom;
        apb(1'b1, GTC_OFS_RELOAD, ld);
        apb(1'b1, GTC_OFS_ICLR, 32'h0);
        c = '{cap_en: 1'b1, evt_sel: sel, default: '0};
        apb(1'b1, GTC_OFS_CTRL, {14'h0, c});
        pulse(sel + 5'h1);
        apb(1'b0, GTC_OFS_SNAP, 32'h0);
        `CHK("other source", 32'h0, rdat)
        pulse(sel);
        apb(1'b0, GTC_OFS_SNAP, 32'h0);
        `CHK("snapshot", ld, rdat)
        apb(1'b0, GTC_OFS_STAT, 32'h0);
        `CHK("capture flag", 32'h2, rdat)
        apb(1'b1, GTC_OFS_STAT, 32'h2);
        apb(1'b0, GTC_OFS_STAT, 32'h0);
        `CHK("flag cleared", 32'h0, rdat)
        c.cap_en = 1'b0;
        apb(1'b1, GTC_OFS_CTRL, {14'h0, c});
        apb(1'b1, GTC_OFS_RELOAD, ~ld);
        apb(1'b1, GTC_OFS_ICLR, 32'h0);
        pulse(sel);
        apb(1'b0, GTC_OFS_SNAP, 32'h0);
        `CHK("disarmed", ld, rdat)
        $display("test capture done");
        end_sim();
    end
endmodule : test_general_timer_control
`default_nettype wire
